/* File: hw/ioex_map.vh */
// Register map, field layout and timing constants of the expander control.
`ifndef IOEX_MAP_VH
`define IOEX_MAP_VH

// Register byte offsets.
`define IOEX_OFF_INTF      12'h430
`define IOEX_OFF_ADDR_A    12'h434
`define IOEX_OFF_ADDR_B    12'h438
`define IOEX_OFF_IRQ_STAT  12'h440
`define IOEX_OFF_IRQ_MASK  12'h444

// Fields of the interface control register.
`define IOEX_F_DATA    15:0
`define IOEX_B_RELOAD  24
`define IOEX_B_TM      25
`define IOEX_F_SEL     30:28
`define IOEX_B_DONE    31

// Address fields.
`define IOEX_F_ADR0    7:1
`define IOEX_F_ADR2    23:17
`define IOEX_F_ADR4    7:1

// Select codes and expander slots.
`define IOEX_SEL_E0    3'h0
`define IOEX_SEL_E2    3'h2
`define IOEX_SEL_E4    3'h4
`define IOEX_IDX_NONE  2'h3

// Reset values.
`define IOEX_ADDR_RST  7'h00
`define IOEX_DATA_RST  16'h0000
`define IOEX_WORD_RST  32'h0000_0000

// Expander model: pins set in the mask are inputs.
`define IOEX_IN_MASK   16'h00FF
`define IOEX_CMD_IN    8'h00
`define IOEX_CMD_OUT   8'h02
`define IOEX_CMD_CFG   8'h06

// Interrupt status bits.
`define IOEX_IRQ_DONE  0
`define IOEX_IRQ_NACK  1
`define IOEX_IRQ_W     2

// Bus timing: quarter of a 100 kHz bit, rounded up to whole cycles.
`define IOEX_CLK_MHZ   25
`define IOEX_T_QTR_NS  2500
`define IOEX_QTR_CYC   ((`IOEX_T_QTR_NS*`IOEX_CLK_MHZ+999)/1000)
`define IOEX_BIT_LAST  4'h8

// Byte engine operations.
`define IOEX_OP_START  2'h0
`define IOEX_OP_STOP   2'h1
`define IOEX_OP_WR     2'h2
`define IOEX_OP_RD     2'h3

// Byte sources of a sequence step.
`define IOEX_SRC_AW    4'h0
`define IOEX_SRC_AR    4'h1
`define IOEX_SRC_CIN   4'h2
`define IOEX_SRC_COUT  4'h3
`define IOEX_SRC_CCFG  4'h4
`define IOEX_SRC_OLO   4'h5
`define IOEX_SRC_OHI   4'h6
`define IOEX_SRC_DLO   4'h7
`define IOEX_SRC_DHI   4'h8
`define IOEX_SRC_RLO   4'h9
`define IOEX_SRC_RHI   4'hA
`define IOEX_SRC_NONE  4'hB

// First step of each job.
`define IOEX_ST_REFRESH 5'h00
`define IOEX_ST_OUTWR   5'h07
`define IOEX_ST_INIT    5'h0D
`endif

/* File: hw/ioex_smb_engine.v */
// Byte level SMBus master engine with clock stretching support.
`timescale 1ns/1ps
`include "ioex_map.vh"
module ioex_smb_engine (
  input  wire       clk_sys,    // Core clock.
  input  wire       rst_q_b,    // Synchronised reset, active low.
  input  wire       op_go,      // Start one operation, pulse.
  input  wire [1:0] op_code,    // Start, stop, write or read.
  input  wire [7:0] op_tx,      // Byte to send.
  input  wire       op_nack,    // Answer a read with NACK.
  input  wire       scl_in,     // Clock pin level.
  input  wire       sda_in,     // Data pin level.
  output reg        scl_oe_b,   // Clock pin drive, low pulls low.
  output reg        sda_oe_b,   // Data pin drive, low pulls low.
  output reg        op_busy,    // Operation in progress.
  output reg        op_done,    // Operation finished, pulse.
  output reg  [7:0] op_rx,      // Byte received.
  output reg        op_ack_bad  // Write was not acknowledged.
);
  localparam [31:0] QTR_CYC = `IOEX_QTR_CYC;
  wire [7:0] qtr_max = QTR_CYC[7:0] - 8'h01;

  reg       scl_s1_r;
  reg       scl_s2_r;
  reg       sda_s1_r;
  reg       sda_s2_r;
  reg [7:0] div_r;
  reg [1:0] q_r;
  reg [3:0] bit_r;
  reg [1:0] op_r;
  reg [8:0] tx_r;
  reg [8:0] rx_r;
  reg       want_scl;
  reg       want_sda;

  // Pin levels per quarter; a one means the pin is released.
  always @* begin
    want_scl = 1'b1;
    want_sda = 1'b1;
    if (op_busy) begin
      case (op_r)
        `IOEX_OP_START: begin
          want_scl = (q_r == 2'h1) || (q_r == 2'h2);
          want_sda = (q_r == 2'h0) || (q_r == 2'h1);
        end
        `IOEX_OP_STOP: begin
          want_scl = (q_r != 2'h0);
          want_sda = (q_r == 2'h3);
        end
        default: begin
          want_scl = (q_r == 2'h1) || (q_r == 2'h2);
          want_sda = tx_r[8];
        end
      endcase
    end
  end

  // The pins come from another party, so two flops come first.
  always @(posedge clk_sys or negedge rst_q_b) begin
    if (!rst_q_b) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
    end
  end

  // A released clock that stays low holds the quarter: clock stretching.
  always @(posedge clk_sys or negedge rst_q_b) begin
    if (!rst_q_b) begin
      div_r      <= 8'h00;
      q_r        <= 2'h0;
      bit_r      <= 4'h0;
      op_r       <= 2'h0;
      tx_r       <= 9'h1FF;
      rx_r       <= 9'h000;
      op_busy    <= 1'b0;
      op_done    <= 1'b0;
      op_rx      <= 8'h00;
      op_ack_bad <= 1'b0;
      scl_oe_b   <= 1'b1;
      sda_oe_b   <= 1'b1;
    end else begin
      op_done  <= 1'b0;
      // Between operations the pins keep their last level; releasing them
      // there would put a stray clock pulse or a false stop on the bus.
      if (op_busy) begin
        scl_oe_b <= want_scl;
        sda_oe_b <= want_sda;
      end
      if (!op_busy) begin
        if (op_go) begin
          op_busy <= 1'b1;
          op_r    <= op_code;
          div_r   <= 8'h00;
          q_r     <= 2'h0;
          bit_r   <= 4'h0;
          tx_r    <= (op_code == `IOEX_OP_RD) ? {8'hFF, op_nack}
                                               : {op_tx, 1'b1};
        end
      end else if (div_r != qtr_max) begin
        div_r <= div_r + 8'h01;
      end else if (!(want_scl && !scl_s2_r)) begin
        div_r <= 8'h00;
        q_r   <= q_r + 2'h1;
        if (q_r == 2'h2 && op_r[1])
          rx_r <= {rx_r[7:0], sda_s2_r};
        if (q_r == 2'h3) begin
          if (!op_r[1] || bit_r == `IOEX_BIT_LAST) begin
            op_busy    <= 1'b0;
            op_done    <= 1'b1;
            op_rx      <= rx_r[8:1];
            op_ack_bad <= (op_r == `IOEX_OP_WR) && rx_r[0];
          end else begin
            bit_r <= bit_r + 4'h1;
            tx_r  <= {tx_r[7:0], 1'b1};
          end
        end
      end
    end
  end
endmodule // ioex_smb_engine

/* File: hw/ioex_ctrl.v */
// Control, status and SMBus sequencing for three I/O expanders.
`timescale 1ns/1ps
`include "ioex_map.vh"
module ioex_ctrl (
  input  wire        clk_sys,     // Core clock, 25 MHz.
  input  wire        rst_b,       // Core reset, active low.
  input  wire        fund_rst_b,  // Fundamental reset, active low.
  input  wire [11:0] reg_addr,    // Register byte address.
  input  wire [31:0] reg_wdata,   // Register write data.
  input  wire        reg_wr,      // Write strobe.
  input  wire        reg_rd,      // Read strobe.
  output reg  [31:0] reg_rdata,   // Read data, cycle after strobe.
  input  wire        addr_lock,   // Locks the address fields.
  input  wire [47:0] core_out,    // Core output values, 16 per slot.
  input  wire        scl_in,      // Clock pin level.
  output reg         scl_out,     // Clock pin value, always low.
  output wire        scl_oe_b,    // Clock pin drive, active low.
  input  wire        sda_in,      // Data pin level.
  output reg         sda_out,     // Data pin value, always low.
  output wire        sda_oe_b,    // Data pin drive, active low.
  output reg         irq          // Level interrupt.
);
  reg        core_s1_r;
  reg        core_s2_r;
  reg        fund_s1_r;
  reg        fund_s2_r;
  reg        done_r;
  reg        tm_r;
  reg  [2:0] sel_r;
  reg  [6:0] adr0_r;
  reg  [6:0] adr2_r;
  reg  [6:0] adr4_r;
  reg        seq_busy_r;
  reg  [4:0] step_r;
  reg  [1:0] jidx_r;
  reg        eng_go_r;
  reg  [7:0] rd_lo_r;
  reg  [7:0] rd_hi_r;
  reg        nack_r;
  reg        rd_valid_r; // Job read inputs back; their bits are refreshed.
  reg  [`IOEX_IRQ_W-1:0] stat_r;
  reg  [`IOEX_IRQ_W-1:0] mask_r;
  reg  [`IOEX_IRQ_W-1:0] stat_nxt;
  reg  [7:0] tx_byte;
  reg  [6:0] jaddr;
  reg [31:0] rd_nxt;
  wire       core_rst_b = rst_b & fund_rst_b;
  wire       eng_done;
  wire       eng_busy;
  wire       eng_ack_bad;
  wire [7:0] eng_rx;
  wire[47:0] tdata_flat;
  wire[47:0] pin_flat;
  wire[15:0] in_mask = `IOEX_IN_MASK; // Pins that are expander inputs.

  // Reset release is synchronised; a fundamental reset also resets the core.
  always @(posedge clk_sys or negedge core_rst_b) begin
    if (!core_rst_b) begin
      core_s1_r <= 1'b0;
      core_s2_r <= 1'b0;
    end else begin
      core_s1_r <= 1'b1;
      core_s2_r <= core_s1_r;
    end
  end

  // Separate copy for the sticky fields.
  always @(posedge clk_sys or negedge fund_rst_b) begin
    if (!fund_rst_b) begin
      fund_s1_r <= 1'b0;
      fund_s2_r <= 1'b0;
    end else begin
      fund_s1_r <= 1'b1;
      fund_s2_r <= fund_s1_r;
    end
  end

  // Map a select code onto a slot; reserved codes give no slot.
  function [1:0] sel_to_idx;
    input [2:0] code;
    begin
      case (code)
        `IOEX_SEL_E0: sel_to_idx = 2'h0;
        `IOEX_SEL_E2: sel_to_idx = 2'h1;
        `IOEX_SEL_E4: sel_to_idx = 2'h2;
        default:      sel_to_idx = `IOEX_IDX_NONE;
      endcase
    end
  endfunction

  // Sequence table: end mark, engine operation, byte source.
  function [6:0] step_ent;
    input [4:0] s;
    begin
      case (s)
        5'h00: step_ent = {1'b0, `IOEX_OP_START, `IOEX_SRC_NONE};
        5'h01: step_ent = {1'b0, `IOEX_OP_WR, `IOEX_SRC_AW};
        5'h02: step_ent = {1'b0, `IOEX_OP_WR, `IOEX_SRC_CIN};
        5'h03: step_ent = {1'b0, `IOEX_OP_START, `IOEX_SRC_NONE};
        5'h04: step_ent = {1'b0, `IOEX_OP_WR, `IOEX_SRC_AR};
        5'h05: step_ent = {1'b0, `IOEX_OP_RD, `IOEX_SRC_RLO};
        5'h06: step_ent = {1'b0, `IOEX_OP_RD, `IOEX_SRC_RHI};
        5'h07: step_ent = {1'b0, `IOEX_OP_START, `IOEX_SRC_NONE};
        5'h08: step_ent = {1'b0, `IOEX_OP_WR, `IOEX_SRC_AW};
        5'h09: step_ent = {1'b0, `IOEX_OP_WR, `IOEX_SRC_COUT};
        5'h0A: step_ent = {1'b0, `IOEX_OP_WR, `IOEX_SRC_OLO};
        5'h0B: step_ent = {1'b0, `IOEX_OP_WR, `IOEX_SRC_OHI};
        5'h0C: step_ent = {1'b1, `IOEX_OP_STOP, `IOEX_SRC_NONE};
        5'h0D: step_ent = {1'b0, `IOEX_OP_START, `IOEX_SRC_NONE};
        5'h0E: step_ent = {1'b0, `IOEX_OP_WR, `IOEX_SRC_AW};
        5'h0F: step_ent = {1'b0, `IOEX_OP_WR, `IOEX_SRC_CCFG};
        5'h10: step_ent = {1'b0, `IOEX_OP_WR, `IOEX_SRC_DLO};
        5'h11: step_ent = {1'b0, `IOEX_OP_WR, `IOEX_SRC_DHI};
        default: step_ent = {1'b1, `IOEX_OP_STOP, `IOEX_SRC_NONE};
      endcase
    end
  endfunction

  // Register decode.
  wire wr_intf = reg_wr && (reg_addr == `IOEX_OFF_INTF);
  wire wr_adra = reg_wr && (reg_addr == `IOEX_OFF_ADDR_A);
  wire wr_adrb = reg_wr && (reg_addr == `IOEX_OFF_ADDR_B);
  wire wr_stat = reg_wr && (reg_addr == `IOEX_OFF_IRQ_STAT);
  wire wr_mask = reg_wr && (reg_addr == `IOEX_OFF_IRQ_MASK);
  wire [1:0] wsel_idx = sel_to_idx(reg_wdata[`IOEX_F_SEL]);
  wire [1:0] cur_idx  = sel_to_idx(sel_r);
  wire       wsel_ok  = (wsel_idx != `IOEX_IDX_NONE);

  // A write to an interface register starts at most one job; the refresh
  // trigger wins over a test-mode data write in the same cycle.
  wire req_refresh = wr_intf && reg_wdata[`IOEX_B_RELOAD] && wsel_ok;
  wire req_outwr   = wr_intf && reg_wdata[`IOEX_B_TM] && wsel_ok &&
                     !reg_wdata[`IOEX_B_RELOAD];
  wire req_init    = !addr_lock && ((wr_adra &&
                     (cur_idx == 2'h0 || cur_idx == 2'h1)) ||
                     (wr_adrb && cur_idx == 2'h2));
  wire       req_any   = req_refresh || req_outwr || req_init;
  wire [4:0] req_step  = req_refresh ? `IOEX_ST_REFRESH :
                         req_outwr   ? `IOEX_ST_OUTWR : `IOEX_ST_INIT;
  wire [1:0] req_idx   = req_init ? cur_idx : wsel_idx;

  // Current step decoded.
  wire [6:0] ent     = step_ent(step_r);
  wire       ent_end = ent[6];
  wire [3:0] ent_src = ent[3:0];
  wire       seq_end = seq_busy_r && eng_done && ent_end;
  wire       nack_any = nack_r || eng_ack_bad;

  // Sticky bus addresses: only the fundamental reset clears them.
  always @(posedge clk_sys or negedge fund_s2_r) begin
    if (!fund_s2_r) begin
      adr0_r <= `IOEX_ADDR_RST;
      adr2_r <= `IOEX_ADDR_RST;
      adr4_r <= `IOEX_ADDR_RST;
    end else if (!addr_lock) begin
      if (wr_adra) begin
        adr0_r <= reg_wdata[`IOEX_F_ADR0];
        adr2_r <= reg_wdata[`IOEX_F_ADR2];
      end
      if (wr_adrb)
        adr4_r <= reg_wdata[`IOEX_F_ADR4];
    end
  end

  // Select, test mode and the done flag; a completion beats a clear.
  always @(posedge clk_sys or negedge core_s2_r) begin
    if (!core_s2_r) begin
      sel_r  <= `IOEX_SEL_E0;
      tm_r   <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (wr_intf) begin
        sel_r <= reg_wdata[`IOEX_F_SEL];
        tm_r  <= reg_wdata[`IOEX_B_TM];
      end
      if (seq_end)
        done_r <= 1'b1;
      else if (wr_intf && reg_wdata[`IOEX_B_DONE])
        done_r <= 1'b0;
    end
  end

  // Per slot: software output values and the last exchanged pin values.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_slot
      reg  [15:0] tdata_r;
      reg  [15:0] pin_r;
      wire [15:0] outv = tm_r ? tdata_r : core_out[gi*16 +: 16];
      always @(posedge clk_sys or negedge core_s2_r) begin
        if (!core_s2_r) begin
          tdata_r <= `IOEX_DATA_RST;
          pin_r   <= `IOEX_DATA_RST;
        end else begin
          if (wr_intf && wsel_idx == gi)
            tdata_r <= reg_wdata[`IOEX_F_DATA] & ~`IOEX_IN_MASK;
          if (seq_end && jidx_r == gi && step_r == 5'h0C) begin
            pin_r <= (outv & ~`IOEX_IN_MASK) |
                     (pin_r & `IOEX_IN_MASK & {16{!rd_valid_r}}) |
                     ({rd_hi_r, rd_lo_r} & `IOEX_IN_MASK &
                      {16{rd_valid_r}});
          end
        end
      end
      assign tdata_flat[gi*16 +: 16] = outv;
      assign pin_flat[gi*16 +: 16]   = pin_r;
    end
  endgenerate

  // Step sequencer. Requests arriving while a job runs are dropped.
  always @(posedge clk_sys or negedge core_s2_r) begin
    if (!core_s2_r) begin
      seq_busy_r <= 1'b0;
      step_r     <= 5'h00;
      jidx_r     <= 2'h0;
      eng_go_r   <= 1'b0;
      rd_lo_r    <= 8'h00;
      rd_hi_r    <= 8'h00;
      nack_r     <= 1'b0;
      rd_valid_r <= 1'b0;
    end else begin
      eng_go_r <= 1'b0;
      if (!seq_busy_r) begin
        if (req_any) begin
          seq_busy_r <= 1'b1;
          step_r     <= req_step;
          jidx_r     <= req_idx;
          eng_go_r   <= 1'b1;
          nack_r     <= 1'b0;
          rd_valid_r <= 1'b0;
        end
      end else if (eng_done) begin
        if (eng_ack_bad)
          nack_r <= 1'b1;
        if (ent_src == `IOEX_SRC_RLO)
          rd_lo_r <= eng_rx;
        if (ent_src == `IOEX_SRC_RHI) begin
          rd_hi_r    <= eng_rx;
          rd_valid_r <= 1'b1;
        end
        if (ent_end) begin
          seq_busy_r <= 1'b0;
        end else begin
          step_r   <= step_r + 5'h01;
          eng_go_r <= 1'b1;
        end
      end
    end
  end

  // Byte to send for the current step; addresses come from sticky fields.
  always @* begin
    case (jidx_r)
      2'h0:    jaddr = adr0_r;
      2'h1:    jaddr = adr2_r;
      default: jaddr = adr4_r;
    endcase
    case (ent_src)
      `IOEX_SRC_AW:   tx_byte = {jaddr, 1'b0};
      `IOEX_SRC_AR:   tx_byte = {jaddr, 1'b1};
      `IOEX_SRC_CIN:  tx_byte = `IOEX_CMD_IN;
      `IOEX_SRC_COUT: tx_byte = `IOEX_CMD_OUT;
      `IOEX_SRC_CCFG: tx_byte = `IOEX_CMD_CFG;
      `IOEX_SRC_OLO:  tx_byte = tdata_flat[jidx_r*16 +: 8];
      `IOEX_SRC_OHI:  tx_byte = tdata_flat[jidx_r*16+8 +: 8];
      `IOEX_SRC_DLO:  tx_byte = in_mask[7:0];
      `IOEX_SRC_DHI:  tx_byte = in_mask[15:8];
      default:        tx_byte = 8'hFF;
    endcase
  end

  ioex_smb_engine u_eng (
    .clk_sys    (clk_sys),
    .rst_q_b    (core_s2_r),
    .op_go      (eng_go_r),
    .op_code    (ent[5:4]),
    .op_tx      (tx_byte),
    .op_nack    (ent_src == `IOEX_SRC_RHI),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .scl_oe_b   (scl_oe_b),
    .sda_oe_b   (sda_oe_b),
    .op_busy    (eng_busy),
    .op_done    (eng_done),
    .op_rx      (eng_rx),
    .op_ack_bad (eng_ack_bad)
  );

  // Sticky event bits; a new event wins over a clearing write.
  always @* begin
    stat_nxt = stat_r;
    if (wr_stat)
      stat_nxt = stat_nxt & ~reg_wdata[`IOEX_IRQ_W-1:0];
    if (seq_end)
      stat_nxt[`IOEX_IRQ_DONE] = 1'b1;
    if (seq_end && nack_any)
      stat_nxt[`IOEX_IRQ_NACK] = 1'b1;
  end

  // Interrupt registers and the level output.
  always @(posedge clk_sys or negedge core_s2_r) begin
    if (!core_s2_r) begin
      stat_r  <= {`IOEX_IRQ_W{1'b0}};
      mask_r  <= {`IOEX_IRQ_W{1'b0}};
      irq     <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      stat_r  <= stat_nxt;
      if (wr_mask)
        mask_r <= reg_wdata[`IOEX_IRQ_W-1:0];
      irq     <= |(stat_r & mask_r);
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // Read mux; the trigger and reserved bits read zero.
  always @* begin
    rd_nxt = `IOEX_WORD_RST;
    case (reg_addr)
      `IOEX_OFF_INTF: begin
        rd_nxt[`IOEX_B_DONE] = done_r;
        rd_nxt[`IOEX_F_SEL]  = sel_r;
        rd_nxt[`IOEX_B_TM]   = tm_r;
        if (cur_idx != `IOEX_IDX_NONE)
          rd_nxt[`IOEX_F_DATA] = pin_flat[cur_idx*16 +: 16];
      end
      `IOEX_OFF_ADDR_A: begin
        rd_nxt[`IOEX_F_ADR0] = adr0_r;
        rd_nxt[`IOEX_F_ADR2] = adr2_r;
      end
      `IOEX_OFF_ADDR_B: rd_nxt[`IOEX_F_ADR4] = adr4_r;
      `IOEX_OFF_IRQ_STAT: rd_nxt[`IOEX_IRQ_W-1:0] = stat_r;
      `IOEX_OFF_IRQ_MASK: rd_nxt[`IOEX_IRQ_W-1:0] = mask_r;
      default: rd_nxt = `IOEX_WORD_RST;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always @(posedge clk_sys or negedge core_s2_r) begin
    if (!core_s2_r)
      reg_rdata <= `IOEX_WORD_RST;
    else
      reg_rdata <= reg_rd ? rd_nxt : `IOEX_WORD_RST;
  end
endmodule // ioex_ctrl

/* File: dv/ioex_slave_model.sv */
// Behavioural SMBus I/O expander that answers the control block.
`timescale 1ns/1ps
module ioex_slave_model (
  input  wire scl,     // Bus clock level.
  input  wire sda,     // Bus data level.
  input  wire slow,    // Stretch each low phase of the clock.
  output reg  scl_rel, // Clock release, low pulls low.
  output reg  sda_rel  // Data release, low pulls low.
);
  reg [7:0] sh;
  reg [7:0] wb [0:3];
  reg [3:0] cnt;
  reg [1:0] wi;
  reg [1:0] ri;
  reg       act;
  reg       hdr;
  reg       rdm;
  wire [7:0] tx = ri[0] ? 8'hC3 : 8'h5A; // Input pins, low byte first.
  // Both lines start released; the pull-ups make them high.
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    act = 1'b0;
  end
  // A start or repeated start opens a new address phase.
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    hdr = 1'b1;
    rdm = 1'b0;
    cnt = 4'h0;
    wi = 2'h0;
    ri = 2'h0;
  end
  // A stop ends the transaction.
  always @(posedge sda) if (scl === 1'b1) act = 1'b0;
  // Bits are taken on the rising clock edge.
  always @(posedge scl) if (act) begin
    cnt = cnt + 4'h1;
    if (cnt < 4'h9) sh = {sh[6:0], sda};
  end
  // Line changes happen only in the low phase, so no false start or stop.
  always @(negedge scl) if (act) begin
    sda_rel = 1'b1;
    if (cnt == 4'h8 && !rdm) begin
      sda_rel = 1'b0; // Acknowledge address and written bytes.
      wb[wi] = sh;
      wi = wi + 2'h1;
      rdm = hdr & sh[0];
    end
    if (cnt == 4'h9) begin
      cnt = 4'h0;
      if (rdm && !hdr) ri = ri + 2'h1;
      hdr = 1'b0;
    end
    if (rdm && !hdr && ri < 2'h2 && cnt < 4'h8) sda_rel = tx[3'h7 - cnt[2:0]];
  end
  // Slow mode holds the clock low after each fall to force stretching; the
  // hold outlasts the master's own low phase and release check.
  always @(negedge scl) if (act && slow) begin
    scl_rel = 1'b0;
    #9000 scl_rel = 1'b1;
  end
endmodule // ioex_slave_model

/* File: dv/ioex_ctrl_assertions.sv */
// Checker of the expander control register behaviour.
`timescale 1ns/1ps
`include "ioex_map.vh"
module ioex_ctrl_assertions (
  input wire        clk_sys,    // Core clock.
  input wire        rst_b,      // Core reset, active low.
  input wire        fund_rst_b, // Fundamental reset, active low.
  input wire [11:0] reg_addr,   // Register address.
  input wire [31:0] reg_wdata,  // Write data.
  input wire        reg_wr,     // Write strobe.
  input wire        reg_rd,     // Read strobe.
  input wire [31:0] reg_rdata,  // Read data.
  input wire        addr_lock,  // Address lock.
  input wire        irq         // Interrupt.
);
  localparam [11:0] AI = `IOEX_OFF_INTF;
  localparam [11:0] AA = `IOEX_OFF_ADDR_A;
  localparam [11:0] AB = `IOEX_OFF_ADDR_B;
  localparam [11:0] AM = `IOEX_OFF_IRQ_MASK;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b || !fund_rst_b);
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_trig_zero;
    reg_rd && reg_addr == AI |=> !reg_rdata[24];
  endproperty
  a_trig_zero: assert property (p_trig_zero)
    else $error("trigger read as one");
  property p_a_resv;
    reg_rd && reg_addr == AA |=> (reg_rdata & 32'hFF01_FF01) == 32'h0;
  endproperty
  a_a_resv: assert property (p_a_resv)
    else $error("reserved address bits set");
  property p_b_fmt;
    reg_wr && !addr_lock && reg_addr == AB ##1 reg_rd && reg_addr == AB
      |=> reg_rdata == ($past(reg_wdata, 2) & 32'h0000_00FE);
  endproperty
  a_b_fmt: assert property (p_b_fmt)
    else $error("second address readback wrong");
  property p_lock;
    reg_rd && reg_addr == AA ##1 reg_wr && addr_lock && reg_addr == AA
      ##1 reg_rd && reg_addr == AA |=> reg_rdata == $past(reg_rdata, 2);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked address changed");
  property p_sel_rb;
    reg_wr && reg_addr == AI ##1 reg_rd && reg_addr == AI
      |=> (reg_rdata & 32'h7200_0000) == ($past(reg_wdata, 2) & 32'h7200_0000);
  endproperty
  a_sel_rb: assert property (p_sel_rb)
    else $error("select or test mode readback wrong");
  property p_done_clr;
    reg_wr && reg_addr == AI && reg_wdata[31] ##1 reg_rd && reg_addr == AI
      |=> !reg_rdata[31];
  endproperty
  a_done_clr: assert property (p_done_clr)
    else $error("done not cleared");
  property p_irq_mask;
    reg_wr && reg_addr == AM && reg_wdata == 32'h0 |-> ##2 !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
endmodule // ioex_ctrl_assertions
bind ioex_ctrl ioex_ctrl_assertions ioex_ctrl_assertions_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .fund_rst_b(fund_rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .addr_lock(addr_lock),
  .irq(irq));

/* File: dv/tb_top.sv */
// Self-checking bench of the expander control block.
`timescale 1ns/1ps
`include "ioex_map.vh"
module tb_top;
  localparam [11:0] AI = `IOEX_OFF_INTF;
  localparam [11:0] AA = `IOEX_OFF_ADDR_A;
  localparam [11:0] AB = `IOEX_OFF_ADDR_B;
  localparam [11:0] AS = `IOEX_OFF_IRQ_STAT;
  localparam [11:0] AM = `IOEX_OFF_IRQ_MASK;
  reg         clk_sys, rst_b, fund_rst_b, reg_wr, reg_rd, addr_lock, slow;
  reg  [11:0] reg_addr;
  reg  [31:0] reg_wdata, q;
  reg  [47:0] core_out;
  wire [31:0] reg_rdata;
  wire        scl_oe_b, sda_oe_b, m_scl, m_sda, irq, scl_o, sda_o;
  wire        scl = scl_oe_b & m_scl; // Pull-up wins once all release.
  wire        sda = sda_oe_b & m_sda;
  integer     mismatches, samples_checked, n;
  ioex_ctrl ioex_ctrl_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .fund_rst_b(fund_rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .addr_lock(addr_lock), .core_out(core_out), .scl_in(scl),
    .scl_out(scl_o), .scl_oe_b(scl_oe_b), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_b(sda_oe_b), .irq(irq));
  ioex_slave_model ioex_slave_model_inst (.scl(scl), .sda(sda),
    .slow(slow), .scl_rel(m_scl), .sda_rel(m_sda));
  // Core clock, 40 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // One bus cycle; q catches the data of the read issued just before.
  task op(input w, input r, input [11:0] a, input [31:0] d);
    begin
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      q = reg_rdata;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  task rdq(input [11:0] a);
    begin
      op(1'b0, 1'b1, a, 32'h0);
      op(1'b0, 1'b0, a, 32'h0);
    end
  endtask
  task chk(input [63:0] nm, input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("FAIL %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task rd(input [11:0] a, input [31:0] m, input [31:0] e, input [63:0] nm);
    begin
      rdq(a);
      chk(nm, q & m, e);
    end
  endtask
  // Poll done; a job that never ends is cut short as a mismatch.
  task wait_done;
    begin
      n = 0;
      q = 32'h0;
      while (q[31] !== 1'b1 && n < 500) begin
        repeat (100) op(1'b0, 1'b0, AI, 32'h0);
        rdq(AI);
        n = n + 1;
      end
      if (q[31] !== 1'b1) begin
        chk("done", 32'h0, 32'h8000_0000);
        test_done;
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Main sequence: reset, addresses, init, test write, refresh, resets.
  initial begin
    mismatches = 0;
    samples_checked = 0;
    {rst_b, fund_rst_b, reg_wr, reg_rd, addr_lock, slow} = 6'h00;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    core_out = 48'h0;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    fund_rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(AI, 32'hFFFF_FFFF, 32'h0, "intf");
    rd(AA, 32'hFFFF_FFFF, 32'h0, "addr_a");
    rd(AB, 32'hFFFF_FFFF, 32'h0, "addr_b");
    // Expander 4 is not selected, so this write starts no job.
    wr(AB, 32'hFFFF_FF6B);
    rd(AB, 32'hFFFF_FFFF, 32'h6A, "addr_b");
    addr_lock <= 1'b1;
    op(1'b0, 1'b1, AA, 32'h0);
    wr(AA, 32'hFFFF_FFFF);
    rd(AA, 32'hFFFF_FFFF, 32'h0, "locked");
    addr_lock <= 1'b0;
    wr(AM, 32'h1);
    wr(AA, 32'hFF66_FF43);
    rd(AA, 32'hFFFF_FFFF, 32'h0066_0042, "addr_a");
    wait_done;
    chk("tgt", ioex_slave_model_inst.wb[0], 32'h42);
    chk("cmd", ioex_slave_model_inst.wb[1], 32'h06);
    chk("irq", irq, 32'h1);
    rd(AS, 32'h3, 32'h1, "stat");
    wr(AI, 32'h0000_0000);
    rd(AI, 32'h8000_0000, 32'h8000_0000, "done");
    wr(AI, 32'h8000_0000);
    rd(AI, 32'h8000_0000, 32'h0, "done");
    wr(AM, 32'h0);
    wr(AS, 32'h3);
    rd(AS, 32'h3, 32'h0, "stat");
    // Test mode: written data drive the output byte.
    wr(AI, 32'h0200_BEEF);
    wait_done;
    chk("out_hi", ioex_slave_model_inst.wb[3], 32'hBE);
    chk("out_lo", ioex_slave_model_inst.wb[2], 32'h00);
    wr(AI, 32'h8000_0000);
    // Refresh with the far side stretching the clock.
    core_out <= 48'h0000_0000_6B00;
    slow <= 1'b1;
    wr(AI, 32'h0100_0000);
    rd(AI, 32'h0100_0000, 32'h0, "trig");
    wait_done;
    chk("pins", q & 32'h8300_FFFF, 32'h8000_6B5A);
    chk("core_hi", ioex_slave_model_inst.wb[3], 32'h6B);
    chk("pin_out", {scl_o, sda_o}, 32'h0);
    for (n = 0; n < 6; n = n + 2) begin
      wr(AI, {1'b0, n[2:0], 28'h0});
      rd(AI, 32'h7000_0000, {1'b0, n[2:0], 28'h0}, "select");
    end
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(AA, 32'hFFFF_FFFF, 32'h0066_0042, "sticky");
    rd(AI, 32'hFFFF_FFFF, 32'h0, "hot");
    fund_rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    fund_rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(AA, 32'hFFFF_FFFF, 32'h0, "fund");
    test_done;
  end
endmodule // tb_top
